// ---- shared/dipu_pkg.sv ----
// Functional notes
// [RQ1] Debounced levels, input n at bit n-1
// [RQ2] Pulse transmit event on any debounced change
// [RQ3] Same levels offered as 32-bit read word
// [RQ4] Config bits 0-7 enable per-input pull-ups
// [RQ5] Config bit 8: single ended or differential
// [RQ6] Config reachable as 16-bit and 32-bit objects
// [RQ7] Function array, entry 0 returns count
// [RQ8] Codes 0 and 1 do nothing
// [RQ9] Codes 2/3 reset on rise/fall edge
// [RQ10] Codes 4-7 positive/negative limit, polarity by parity
// [RQ11] Codes 8/9 motor over-temperature, high/low active
// [RQ12] Disable codes; 10/11 also clear faults
// [RQ13] Codes 12/13 reset on edge, disable on level
// [RQ14] Codes 14/15 home switch, high/low active
// [RQ15] Code 19 PWM sync, high-speed pins only
// [RQ16] Codes 20/21 halt motor while level holds
// [RQ17] Codes 22/23 high-resolution analog divide
// [RQ18] Codes 24/25 capture position, high-speed pins only
// [RQ19] Codes 26/27 count edges, upper byte selects
// [RQ20] Debounce array, entry 0 returns count
// [RQ21] Debounce time in ms, 0 to 10000
// [RQ22] Unlisted codes behave as no function
package dipu_pkg;
    localparam int NPIN = 16;
    localparam int DEB_W = 14;

    // Object indices
    localparam logic [15:0] IDX_LEVELS   = 16'h2190;
    localparam logic [15:0] IDX_CFG      = 16'h2191;
    localparam logic [15:0] IDX_FUNC     = 16'h2192;
    localparam logic [15:0] IDX_DEB      = 16'h2195;
    localparam logic [15:0] IDX_LEVELS_W = 16'h219A;
    localparam logic [15:0] IDX_CFG_W    = 16'h219C;

    // Config field layout and reset values
    localparam int PULL_W   = 8;
    localparam int DIFF_BIT = 8;
    localparam int CFG_W    = 9;
    localparam logic [CFG_W-1:0] CFG_RST  = 9'h000;
    localparam logic [15:0]      FUNC_RST = 16'h0000;
    localparam logic [DEB_W-1:0] DEB_RST  = 14'h0000;
    localparam logic [15:0]      DEB_MAX  = 16'h2710;

    // Pins able to carry high-speed functions
    localparam logic [NPIN-1:0] HS_MASK = 16'h0003;

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int MS_NS         = 1000000;
    localparam int TICK_CYC      = MS_NS / CLK_PERIOD_NS;

    // Function codes
    localparam logic [7:0] FN_RST_RISE  = 8'h02;
    localparam logic [7:0] FN_RST_FALL  = 8'h03;
    localparam logic [7:0] FN_PLIM_HI   = 8'h04;
    localparam logic [7:0] FN_PLIM_LO   = 8'h05;
    localparam logic [7:0] FN_NLIM_HI   = 8'h06;
    localparam logic [7:0] FN_NLIM_LO   = 8'h07;
    localparam logic [7:0] FN_TEMP_HI   = 8'h08;
    localparam logic [7:0] FN_TEMP_LO   = 8'h09;
    localparam logic [7:0] FN_DISCL_HI  = 8'h0A;
    localparam logic [7:0] FN_DISCL_LO  = 8'h0B;
    localparam logic [7:0] FN_RSTDIS_HI = 8'h0C;
    localparam logic [7:0] FN_RSTDIS_LO = 8'h0D;
    localparam logic [7:0] FN_HOME_HI   = 8'h0E;
    localparam logic [7:0] FN_HOME_LO   = 8'h0F;
    localparam logic [7:0] FN_DIS_HI    = 8'h10;
    localparam logic [7:0] FN_DIS_LO    = 8'h11;
    localparam logic [7:0] FN_PWM_SYNC  = 8'h13;
    localparam logic [7:0] FN_HALT_HI   = 8'h14;
    localparam logic [7:0] FN_HALT_LO   = 8'h15;
    localparam logic [7:0] FN_HRDIV_HI  = 8'h16;
    localparam logic [7:0] FN_HRDIV_LO  = 8'h17;
    localparam logic [7:0] FN_CAP_RISE  = 8'h18;
    localparam logic [7:0] FN_CAP_FALL  = 8'h19;
    localparam logic [7:0] FN_CNT_RISE  = 8'h1A;
    localparam logic [7:0] FN_CNT_FALL  = 8'h1B;
endpackage : dipu_pkg

// ---- rtl/dipu_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module dipu_top #(
    parameter int TICK_CYC_P = dipu_pkg::TICK_CYC
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Input pins
    input  wire logic [dipu_pkg::NPIN-1:0]     pin_in,
    // Object access port
    input  wire logic                          obj_rd,
    input  wire logic                          obj_wr,
    input  wire logic [15:0]                   obj_index,
    input  wire logic [7:0]                    obj_sub,
    input  wire logic [31:0]                   obj_wdata,
    output logic      [31:0]                   obj_rdata,
    output logic                               obj_ack,
    output logic                               obj_err,
    // Pin electrical control
    output logic      [dipu_pkg::PULL_W-1:0]   pullup_en,
    output logic                               diff_mode,
    // Pin function results
    output logic                               pdo_event,
    output logic                               dev_reset_req,
    output logic                               fault_clear,
    output logic                               drive_disable,
    output logic                               pos_limit,
    output logic                               neg_limit,
    output logic                               motor_overtemp,
    output logic                               home_switch,
    output logic                               motion_halt,
    output logic                               hires_divide,
    output logic                               pwm_sync,
    output logic                               pos_capture,
    output logic                               count_pulse,
    output logic      [7:0]                    count_sel
);
    import dipu_pkg::*;

    localparam int DIV_W = $clog2(TICK_CYC_P + 1);

    typedef struct packed {
        logic [NPIN-1:0]             s1;
        logic [NPIN-1:0]             s2;
        logic [NPIN-1:0]             lvl;
        logic [NPIN-1:0][DEB_W-1:0]  dcnt;
        logic [NPIN-1:0][DEB_W-1:0]  deb;
        logic [NPIN-1:0][15:0]       fn;
        logic [CFG_W-1:0]            cfg;
        logic [DIV_W-1:0]            div;
        logic                        tick;
        logic [31:0]                 rdata;
        logic                        ack;
        logic                        err;
        logic                        pdo;
        logic                        rst_req;
        logic                        fclr;
        logic                        dis;
        logic                        plim;
        logic                        nlim;
        logic                        temp;
        logic                        home;
        logic                        halt;
        logic                        hrdiv;
        logic                        pwm;
        logic                        cap;
        logic                        cnt;
        logic [7:0]                  csel;
    } dipu_state_t;

    dipu_state_t q;
    dipu_state_t d;
    logic [1:0]  rsync_q;
    logic        rst_sync_n;

    // Reset release through two stages
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rsync_q <= 2'h0;
        end else begin
            rsync_q <= {rsync_q[0], 1'b1};
        end
    end
    assign rst_sync_n = rsync_q[1];

    always_comb begin
        logic [NPIN-1:0] rise;
        logic [NPIN-1:0] fall;
        logic [7:0]      code;
        logic            hi;
        logic            hs;
        rise = '0;
        fall = '0;
        code = 8'h00;
        hi   = 1'b0;
        hs   = 1'b0;
        d    = q;

        // Millisecond tick
        if (q.div == DIV_W'(TICK_CYC_P - 1)) begin
            d.div  = '0;
            d.tick = 1'b1;
        end else begin
            d.div  = DIV_W'(q.div + 1'b1);
            d.tick = 1'b0;
        end

        // Pin sync and debounce; counts only while the level differs
        d.s1 = pin_in;
        d.s2 = q.s1;
        for (int i = 0; i < NPIN; i++) begin
            if (q.s2[i] != q.lvl[i]) begin
                if (q.deb[i] == '0 ||
                    (q.tick && DEB_W'(q.dcnt[i] + 1'b1) >= q.deb[i])) begin // [RQ21]
                    d.lvl[i]  = q.s2[i];
                    d.dcnt[i] = '0;
                end else if (q.tick) begin
                    d.dcnt[i] = DEB_W'(q.dcnt[i] + 1'b1);
                end
            end else begin
                d.dcnt[i] = '0;
            end
        end
        rise = d.lvl & ~q.lvl;
        fall = ~d.lvl & q.lvl;
        d.pdo = |(rise | fall); // [RQ2]

        // Pin functions, evaluated on the new debounced level
        d.rst_req = 1'b0;
        d.fclr    = 1'b0;
        d.dis     = 1'b0;
        d.plim    = 1'b0;
        d.nlim    = 1'b0;
        d.temp    = 1'b0;
        d.home    = 1'b0;
        d.halt    = 1'b0;
        d.hrdiv   = 1'b0;
        d.pwm     = 1'b0;
        d.cap     = 1'b0;
        d.cnt     = 1'b0;
        d.csel    = 8'h00;
        for (int i = 0; i < NPIN; i++) begin
            code = q.fn[i][7:0];
            hi   = d.lvl[i];
            hs   = HS_MASK[i];
            case (code)
                FN_RST_RISE:  d.rst_req = d.rst_req | rise[i];             // [RQ9]
                FN_RST_FALL:  d.rst_req = d.rst_req | fall[i];             // [RQ9]
                FN_PLIM_HI:   d.plim    = d.plim | hi;                     // [RQ10]
                FN_PLIM_LO:   d.plim    = d.plim | ~hi;                    // [RQ10]
                FN_NLIM_HI:   d.nlim    = d.nlim | hi;                     // [RQ10]
                FN_NLIM_LO:   d.nlim    = d.nlim | ~hi;                    // [RQ10]
                FN_TEMP_HI:   d.temp    = d.temp | hi;                     // [RQ11]
                FN_TEMP_LO:   d.temp    = d.temp | ~hi;                    // [RQ11]
                FN_DISCL_HI: begin
                    d.dis  = d.dis | hi;                                   // [RQ12]
                    d.fclr = d.fclr | rise[i];                             // [RQ12]
                end
                FN_DISCL_LO: begin
                    d.dis  = d.dis | ~hi;                                  // [RQ12]
                    d.fclr = d.fclr | fall[i];                             // [RQ12]
                end
                FN_RSTDIS_HI: begin
                    d.rst_req = d.rst_req | rise[i];                       // [RQ13]
                    d.dis     = d.dis | hi;                                // [RQ13]
                end
                FN_RSTDIS_LO: begin
                    d.rst_req = d.rst_req | fall[i];                       // [RQ13]
                    d.dis     = d.dis | ~hi;                               // [RQ13]
                end
                FN_HOME_HI:   d.home    = d.home | hi;                     // [RQ14]
                FN_HOME_LO:   d.home    = d.home | ~hi;                    // [RQ14]
                FN_DIS_HI:    d.dis     = d.dis | hi;                      // [RQ12]
                FN_DIS_LO:    d.dis     = d.dis | ~hi;                     // [RQ12]
                FN_PWM_SYNC:  d.pwm     = d.pwm | (hs & hi);               // [RQ15]
                FN_HALT_HI:   d.halt    = d.halt | hi;                     // [RQ16]
                FN_HALT_LO:   d.halt    = d.halt | ~hi;                    // [RQ16]
                FN_HRDIV_HI:  d.hrdiv   = d.hrdiv | hi;                    // [RQ17]
                FN_HRDIV_LO:  d.hrdiv   = d.hrdiv | ~hi;                   // [RQ17]
                FN_CAP_RISE:  d.cap     = d.cap | (hs & rise[i]);          // [RQ18]
                FN_CAP_FALL:  d.cap     = d.cap | (hs & fall[i]);          // [RQ18]
                FN_CNT_RISE, FN_CNT_FALL: begin
                    // Lowest pin wins when two counters fire together
                    if (!d.cnt && ((code == FN_CNT_RISE) ? rise[i] : fall[i])) begin
                        d.cnt  = 1'b1;                                     // [RQ19]
                        d.csel = q.fn[i][15:8];                            // [RQ19]
                    end
                end
                default: ; // Codes 0, 1 and unlisted do nothing [RQ8] [RQ22]
            endcase
        end

        // Object access, answered one cycle later
        d.ack   = obj_rd | obj_wr;
        d.err   = 1'b0;
        d.rdata = 32'h0000_0000;
        if (obj_wr) begin
            case (obj_index)
                IDX_CFG, IDX_CFG_W: d.cfg = obj_wdata[CFG_W-1:0];      // [RQ4] [RQ5] [RQ6]
                IDX_FUNC, IDX_DEB: begin
                    d.err = 1'b1;                                       // [RQ7] [RQ20]
                    for (int i = 0; i < NPIN; i++) begin
                        if (obj_sub == 8'(i + 1)) begin
                            d.err = 1'b0;
                            if (obj_index == IDX_FUNC) begin
                                d.fn[i] = obj_wdata[15:0];
                            end else if (obj_wdata[15:0] > DEB_MAX) begin
                                d.deb[i] = DEB_W'(DEB_MAX);             // [RQ21]
                            end else begin
                                d.deb[i] = obj_wdata[DEB_W-1:0];        // [RQ21]
                            end
                        end
                    end
                end
                default: d.err = 1'b1;
            endcase
        end else if (obj_rd) begin
            case (obj_index)
                IDX_LEVELS:   d.rdata = {16'h0000, q.lvl};                 // [RQ1]
                IDX_LEVELS_W: d.rdata = {{(32 - NPIN){1'b0}}, q.lvl};      // [RQ3]
                IDX_CFG, IDX_CFG_W: d.rdata = {{(32 - CFG_W){1'b0}}, q.cfg}; // [RQ6]
                IDX_FUNC, IDX_DEB: begin
                    if (obj_sub == 8'h00) begin
                        d.rdata = 32'(NPIN);                               // [RQ7] [RQ20]
                    end else begin
                        d.err = 1'b1;
                        for (int i = 0; i < NPIN; i++) begin
                            if (obj_sub == 8'(i + 1)) begin
                                d.err   = 1'b0;
                                d.rdata = (obj_index == IDX_FUNC) ?
                                          {16'h0000, q.fn[i]} :
                                          {18'h00000, q.deb[i]};
                            end
                        end
                    end
                end
                default: d.err = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            q     <= '0;
            q.cfg <= CFG_RST;
            q.fn  <= {NPIN{FUNC_RST}};
            q.deb <= {NPIN{DEB_RST}};
        end else begin
            q <= d;
        end
    end

    assign obj_rdata      = q.rdata;
    assign obj_ack        = q.ack;
    assign obj_err        = q.err;
    assign pullup_en      = q.cfg[PULL_W-1:0];
    assign diff_mode      = q.cfg[DIFF_BIT];
    assign pdo_event      = q.pdo;
    assign dev_reset_req  = q.rst_req;
    assign fault_clear    = q.fclr;
    assign drive_disable  = q.dis;
    assign pos_limit      = q.plim;
    assign neg_limit      = q.nlim;
    assign motor_overtemp = q.temp;
    assign home_switch    = q.home;
    assign motion_halt    = q.halt;
    assign hires_divide   = q.hrdiv;
    assign pwm_sync       = q.pwm;
    assign pos_capture    = q.cap;
    assign count_pulse    = q.cnt;
    assign count_sel      = q.csel;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_sync_n);

    a_pdo_on_change: assert property (q.lvl != $past(q.lvl) |-> pdo_event) // [RQ2]
        else $error("level change without transmit event");
    a_level_read: assert property (obj_rd && !obj_wr && obj_index == IDX_LEVELS // [RQ1]
        |=> obj_ack && obj_rdata == {16'h0000, $past(q.lvl)})
        else $error("levels read mismatch");
    a_wide_read: assert property (obj_rd && !obj_wr && obj_index == IDX_LEVELS_W // [RQ3]
        |=> !obj_err && obj_rdata[15:0] == $past(q.lvl) && obj_rdata[31:16] == 16'h0000)
        else $error("wide levels read mismatch");
    a_pullup_write: assert property (obj_wr && obj_index == IDX_CFG // [RQ4]
        |=> pullup_en == $past(obj_wdata[7:0]))
        else $error("pull-up bits not taken");
    a_diff_write: assert property (obj_wr && obj_index == IDX_CFG // [RQ5]
        |=> diff_mode == $past(obj_wdata[8]))
        else $error("mode bit not taken");
    a_cfg_wide: assert property (obj_wr && obj_index == IDX_CFG_W // [RQ6]
        |=> {diff_mode, pullup_en} == $past(obj_wdata[8:0]))
        else $error("wide config write not taken");
    a_func_count: assert property (obj_rd && !obj_wr && obj_index == IDX_FUNC // [RQ7]
        && obj_sub == 8'h00 |=> obj_rdata == 32'h0000_0010 && !obj_err)
        else $error("function array count wrong");
    a_deb_count: assert property (obj_rd && !obj_wr && obj_index == IDX_DEB // [RQ20]
        && obj_sub == 8'h00 |=> obj_rdata == 32'h0000_0010 && !obj_err)
        else $error("debounce array count wrong");
    a_reset_rise: assert property ($past(q.fn[1][7:0]) == FN_RST_RISE // [RQ9]
        && $rose(q.lvl[1]) |-> dev_reset_req)
        else $error("rising reset edge missed");
    a_deb_zero: assert property (q.deb[0] == '0 && q.s2[0] != q.lvl[0] // [RQ21]
        |=> q.lvl[0] == $past(q.s2[0]))
        else $error("zero debounce not immediate");
    a_deb_hold: assert property (q.s2[0] == q.lvl[0] |=> $stable(q.lvl[0])) // [RQ21]
        else $error("level moved without input change");

    c_pdo: cover property (pdo_event);
    c_reset: cover property (dev_reset_req);
    c_count: cover property (count_pulse);
    c_deb_wait: cover property (q.deb[3] != '0 && $changed(q.lvl[3]));
endmodule : dipu_top
`default_nettype wire

// ---- tb/dipu_switches.sv ----
`timescale 1ns/1ps
`default_nettype none
// Switch and sensor wiring; optional contact chatter after each change
module dipu_switches (
    // Clock
    input  wire logic        clk,
    // Requested settled levels and chatter length in cycles
    input  wire logic [15:0] level_req,
    input  wire logic [3:0]  chatter,
    // Pin drive
    output logic      [15:0] pin_in
);
    logic [15:0] settled;
    logic [15:0] moved;
    int          left;

    initial begin
        settled = 16'h0000;
        moved   = 16'h0000;
        left    = 0;
        pin_in  = 16'h0000;
    end

    // Bouncing contacts toggle the moved pins until the count runs out
    always @(negedge clk) begin
        if (level_req !== settled) begin
            moved   = level_req ^ settled;
            settled = level_req;
            left    = chatter;
        end
        if (left != 0) begin
            pin_in <= pin_in ^ moved;
            left = left - 1;
        end else begin
            pin_in <= settled;
        end
    end
endmodule : dipu_switches
`default_nettype wire

// ---- tb/test_digital_input_pin_unit.sv ----
`timescale 1ns/1ps
`default_nettype none
module test_digital_input_pin_unit;
    import dipu_pkg::*;
    typedef struct packed {
        logic wr; logic [15:0] idx; logic [7:0] sub; logic [31:0] wd; logic [31:0] rd; logic err;
    } dipu_arow_t;
    typedef struct packed {logic [3:0] pin; logic [7:0] code; logic [7:0] mask; logic [3:0] edg;
    } dipu_frow_t;
    logic        clk, rst_n, obj_rd, obj_wr, obj_ack, obj_err, diff_mode, pdo_event;
    logic        dev_reset_req, fault_clear, drive_disable, pos_limit, neg_limit, motor_overtemp;
    logic        home_switch, motion_halt, hires_divide, pwm_sync, pos_capture, count_pulse;
    logic [15:0] level_req, pin_in, obj_index;
    logic [3:0]  chatter;
    logic [7:0]  obj_sub, pullup_en, count_sel, sel_seen;
    logic [31:0] obj_wdata, obj_rdata;
    logic [7:0]  lvl;
    int          mismatches, checked, n_pdo, n_rst, n_fclr, n_cap, n_cnt;
    assign lvl = {drive_disable, pos_limit, neg_limit, motor_overtemp,
                  home_switch, motion_halt, hires_divide, pwm_sync};

    dipu_switches i_sw (.clk(clk), .level_req(level_req), .chatter(chatter), .pin_in(pin_in));
    dipu_top #(.TICK_CYC_P(10)) i_dut (
        .clk(clk), .rst_n(rst_n), .pin_in(pin_in), .obj_rd(obj_rd), .obj_wr(obj_wr),
        .obj_index(obj_index), .obj_sub(obj_sub), .obj_wdata(obj_wdata), .obj_rdata(obj_rdata),
        .obj_ack(obj_ack), .obj_err(obj_err), .pullup_en(pullup_en), .diff_mode(diff_mode),
        .pdo_event(pdo_event), .dev_reset_req(dev_reset_req), .fault_clear(fault_clear),
        .drive_disable(drive_disable), .pos_limit(pos_limit), .neg_limit(neg_limit),
        .motor_overtemp(motor_overtemp), .home_switch(home_switch), .motion_halt(motion_halt),
        .hires_divide(hires_divide), .pwm_sync(pwm_sync), .pos_capture(pos_capture),
        .count_pulse(count_pulse), .count_sel(count_sel));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Pulse tallies, cleared by the bench between cases
    always @(negedge clk) begin
        if (pdo_event === 1'b1) n_pdo++;
        if (dev_reset_req === 1'b1) n_rst++;
        if (fault_clear === 1'b1) n_fclr++;
        if (pos_capture === 1'b1) n_cap++;
        if (count_pulse === 1'b1) begin
            n_cnt++;
            sel_seen = count_sel;
        end
    end

    task automatic cmp_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: bit got %b exp %b", $time, got, exp);
        end
    endtask : cmp_bit

    task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: word got %h exp %h", $time, got, exp);
        end
    endtask : cmp_word

    task automatic access(input dipu_arow_t a);
        @(negedge clk);
        obj_wr = a.wr; obj_rd = !a.wr; obj_index = a.idx; obj_sub = a.sub; obj_wdata = a.wd;
        @(negedge clk);
        // Answer stands for one cycle only, so look before the strobe drops
        cmp_bit(obj_ack, 1'b1);
        cmp_bit(obj_err, a.err);
        cmp_word(obj_rdata, a.rd);
        obj_wr = 1'b0;
        obj_rd = 1'b0;
    endtask : access

    task automatic clear_tally();
        n_pdo = 0; n_rst = 0; n_fclr = 0; n_cap = 0; n_cnt = 0;
        sel_seen = 8'h00;
    endtask : clear_tally

    // Pin low, high, low again; level outputs checked in both states
    task automatic run_row(input dipu_frow_t r);
        logic lo;
        lo = r.code[0] && (r.code != FN_PWM_SYNC);
        access({1'b1, IDX_FUNC, 4'h0, r.pin + 4'h1, 16'h0, 8'h5A, r.code, 32'h0, 1'b0});
        clear_tally();
        repeat (5) @(negedge clk);
        cmp_word({24'h0, lvl}, lo ? {24'h0, r.mask} : 32'h0);
        level_req[r.pin] <= 1'b1;
        repeat (6) @(negedge clk);
        cmp_word({24'h0, lvl}, lo ? 32'h0 : {24'h0, r.mask});
        level_req[r.pin] <= 1'b0;
        repeat (6) @(negedge clk);
        cmp_word(n_pdo, 2);
        cmp_word({n_rst[0], n_fclr[0], n_cap[0], n_cnt[0]}, r.edg);
        cmp_word(n_rst + n_fclr + n_cap + n_cnt, r.edg[0] + r.edg[1] + r.edg[2] + r.edg[3]);
        if (r.edg[0]) cmp_word(sel_seen, 8'h5A);
        access({1'b1, IDX_FUNC, 4'h0, r.pin + 4'h1, 32'h0, 32'h0, 1'b0});
    endtask : run_row

    task automatic finish_test();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    dipu_arow_t arows [15] = '{
        '{0, IDX_LEVELS, 0, 0, 32'h8001, 0},
        '{0, IDX_LEVELS_W, 0, 0, 32'h8001, 0},
        '{1, IDX_CFG, 0, 32'h1FF, 0, 0},
        '{0, IDX_CFG_W, 0, 0, 32'h1FF, 0},
        '{1, IDX_CFG_W, 0, 32'h0A5, 0, 0},
        '{0, IDX_CFG, 0, 0, 32'h0A5, 0},
        '{0, IDX_FUNC, 0, 0, 32'd16, 0},
        '{1, IDX_FUNC, 0, 32'h5, 0, 1},
        '{1, IDX_FUNC, 17, 32'h5, 0, 1},
        '{0, IDX_DEB, 0, 0, 32'd16, 0},
        '{1, IDX_DEB, 1, 32'h3000, 0, 0},
        '{0, IDX_DEB, 1, 0, {16'h0, DEB_MAX}, 0},
        '{1, IDX_LEVELS, 0, 32'h1, 0, 1},
        '{1, IDX_LEVELS_W, 0, 32'h1, 0, 1},
        '{0, 16'h2193, 0, 0, 0, 1}};
    dipu_frow_t frows [32] = '{
        '{1, 0, 0, 0}, '{1, 1, 0, 0}, '{1, 4, 8'h40, 0}, '{1, 5, 8'h40, 0}, '{1, 6, 8'h20, 0},
        '{1, 7, 8'h20, 0}, '{1, 8, 8'h10, 0}, '{1, 9, 8'h10, 0}, '{1, 10, 8'h80, 4},
        '{1, 11, 8'h80, 4}, '{1, 12, 8'h80, 8}, '{1, 13, 8'h80, 8}, '{1, 14, 8'h08, 0},
        '{1, 15, 8'h08, 0}, '{1, 16, 8'h80, 0}, '{1, 17, 8'h80, 0}, '{1, 18, 0, 0},
        '{1, 19, 8'h01, 0}, '{1, 20, 8'h04, 0}, '{1, 21, 8'h04, 0}, '{1, 22, 8'h02, 0},
        '{1, 23, 8'h02, 0}, '{1, 2, 0, 8}, '{1, 3, 0, 8}, '{1, 24, 0, 2}, '{1, 25, 0, 2},
        '{1, 26, 0, 1}, '{1, 27, 0, 1}, '{1, 8'h2C, 0, 0}, '{1, 8'hFF, 0, 0},
        '{2, 19, 0, 0}, '{2, 24, 0, 0}};

    initial begin
        rst_n = 1'b0; obj_rd = 1'b0; obj_wr = 1'b0; obj_index = 16'h0000; obj_sub = 8'h00;
        obj_wdata = 32'h0; level_req = 16'h8001; chatter = 4'h0; sel_seen = 8'h00;
        mismatches = 0; checked = 0;
        clear_tally();
        repeat (12) @(negedge clk);
        cmp_bit(pdo_event | obj_ack | dev_reset_req | drive_disable, 1'b0);
        cmp_word({23'h0, diff_mode, pullup_en}, 32'h0);
        rst_n = 1'b1;
        repeat (10) @(negedge clk);
        foreach (arows[i]) access(arows[i]);
        cmp_word({23'h0, diff_mode, pullup_en}, 32'h0A5);
        access({1'b1, IDX_CFG, 8'h0, 32'h100, 32'h0, 1'b0});
        cmp_word({23'h0, diff_mode, pullup_en}, 32'h100);
        foreach (frows[i]) run_row(frows[i]);
        // Long debounce with chatter: one accepted change, not before a tick
        access({1'b1, IDX_DEB, 8'h4, 32'h2, 32'h0, 1'b0});
        clear_tally();
        chatter = 4'h6;
        level_req[3] <= 1'b1;
        repeat (15) @(negedge clk);
        cmp_word(n_pdo, 0);
        repeat (30) @(negedge clk);
        cmp_word(n_pdo, 1);
        access({1'b0, IDX_LEVELS, 8'h0, 32'h0, 32'h8009, 1'b0});
        // Reset in mid-run clears the configuration
        rst_n = 1'b0;
        @(negedge clk);
        cmp_word({23'h0, diff_mode, pullup_en}, 32'h0);
        rst_n = 1'b1;
        repeat (4) @(negedge clk);
        access({1'b0, IDX_CFG_W, 8'h0, 32'h0, 32'h0, 1'b0});
        finish_test();
    end

    initial begin
        #200000;
        mismatches++;
        finish_test();
    end
endmodule : test_digital_input_pin_unit
`default_nettype wire
